/* verilog/chbc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Narrow bus splits words into two halves
// - Narrow lanes: low little, high big endian
// - Request high; drop before grant falls
// - Release on grant loss or throttle expiry
// - Grant synchronised; arbiter drops after request
// - Grant lost early: release within bound
// - External trigger mode starts the throttle timer
// - Port strobe latches data into register
// - Reset after five sys, four tx clocks
// - Idle after reset until first attention
// - Byte order input selects endianness
// - Attention synchronised, taken on falling edge
// - First attention inits from root pointer
// - Later attentions start command sequence
// - Interrupt is level, selectable polarity
// - Backoff floats bus, then restarts cycle
module chbc_top
    import chbc_pkg::*;
#(
    parameter int RELEASE_MAX  = CHBC_RELEASE_MAX,
    parameter int THROTTLE_MAX = CHBC_THROTTLE_DEF
)(
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    input  wire logic                   hw_reset_i,
    input  wire logic                   serial_transmit_clock_i,
    input  wire logic                   bus_mastership_grant_i,
    input  wire logic                   throttle_trigger_in_i,
    input  wire logic                   throttle_ext_mode_i,
    input  wire logic                   host_attention_strobe_i,
    input  wire logic                   port_strobe_i,
    input  wire logic [CHBC_DATA_W-1:0] host_data_i,
    input  wire logic                   narrow_bus_select_n_i,
    input  wire logic                   byte_order_select_i,
    input  wire logic                   bus_backoff_in_n_i,
    input  wire logic                   xfer_req_i,
    input  wire logic [CHBC_DATA_W-1:0] xfer_data_i,
    input  wire logic                   mem_ready_i,
    input  wire logic                   irq_event_i,
    input  wire logic                   irq_active_high_i,
    output logic                        bus_request_o,
    output logic                        bus_owned_o,
    output logic                        bus_drive_o,
    output logic [CHBC_DATA_W-1:0]      mem_data_o,
    output logic                        mem_strobe_o,
    output logic                        xfer_done_o,
    output logic [CHBC_DATA_W-1:0]      port_latch_o,
    output logic                        device_reset_o,
    output logic                        start_pulse_o,
    output logic [1:0]                  start_kind_o,
    output logic [CHBC_DATA_W-1:0]      start_addr_o,
    output logic                        interrupt_o
);
    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Bounds must fit the counters, refused at elaboration
    if (RELEASE_MAX < 1 || RELEASE_MAX >= (1 << CHBC_CNT_W)) begin
        $error("RELEASE_MAX out of range");
    end
    if (THROTTLE_MAX < 1 || THROTTLE_MAX >= (1 << CHBC_CNT_W)) begin
        $error("THROTTLE_MAX out of range");
    end

    localparam logic [CHBC_CNT_W-1:0] REL_LIM = CHBC_CNT_W'(RELEASE_MAX);
    localparam logic [CHBC_CNT_W-1:0] THR_LIM = CHBC_CNT_W'(THROTTLE_MAX);
    localparam logic [2:0] RST_SYS = 3'(CHBC_RST_SYS_MIN);
    localparam logic [2:0] RST_TX  = 3'(CHBC_RST_TX_MIN);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    chbc_sync_if sy ();

    chbc_sync u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .pins_i  ({port_strobe_i, throttle_trigger_in_i,
                   serial_transmit_clock_i, hw_reset_i,
                   host_attention_strobe_i, bus_mastership_grant_i}),
        .sync    (sy.src)
    );

    // ************************************************************
    // Block state
    // ************************************************************
    typedef struct packed {
        chbc_bus_t              bus;       // Ownership state
        logic [CHBC_CNT_W-1:0]  rel_cnt;   // Cycles since early grant loss
        logic [CHBC_CNT_W-1:0]  thr_cnt;   // Throttle tenure counter
        logic                   thr_run;   // Throttle timer armed
        logic                   trig_d;    // Trigger level, last cycle
        logic                   boff1;     // Backoff sync stage one
        logic                   bus_backoff_in;      // Backoff synchronised
        logic                   half;      // Second half pending
        logic                   done;      // Transfer complete pulse
        logic [CHBC_DATA_W-1:0] mdata;     // Data on memory lanes
        logic                   mstb;      // Memory access strobe
        logic                   port_d;    // Port level, last cycle
        logic [CHBC_DATA_W-1:0] port_reg;  // Host-written latch
        logic                   root_set;  // Root pointer written
        logic [2:0]             rs_cnt;    // Reset system clock count
        logic [2:0]             rt_cnt;    // Reset transmit clock count
        logic                   txc_d;     // Transmit clock last level
        logic                   in_rst;    // Device held in reset
        logic                   attn_d;    // Attention level, last cycle
        logic                   started;   // First attention seen
        logic                   spulse;    // Start pulse
        logic [1:0]             skind;     // Start kind
        logic [CHBC_DATA_W-1:0] saddr;     // Start address
        logic                   irq;       // Interrupt level, true sense
    } chbc_st_t;

    chbc_st_t st;
    chbc_st_t next_st;

    // Byte swap within one word
    function automatic logic [CHBC_DATA_W-1:0] swap(
        input logic [CHBC_DATA_W-1:0] d);
        swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [CHBC_DATA_W-1:0] word;
        word    = '0;
        next_st = st;
        next_st.done   = 1'b0;
        next_st.spulse = 1'b0;
        next_st.mstb   = 1'b0;
        next_st.trig_d = sy.trig;
        next_st.port_d = sy.port;
        next_st.attn_d = sy.attn;
        next_st.txc_d  = sy.serial_transmit_clock;
        next_st.boff1  = ~bus_backoff_in_n_i;
        next_st.bus_backoff_in   = st.boff1;
        next_st.irq    = irq_event_i;

        // Reset qualification by both clocks
        if (sy.rst) begin
            if (st.rs_cnt < RST_SYS)
                next_st.rs_cnt = st.rs_cnt + 3'h1;
            if (sy.serial_transmit_clock && !st.txc_d && st.rt_cnt < RST_TX)
                next_st.rt_cnt = st.rt_cnt + 3'h1;
            if (st.rs_cnt >= RST_SYS && st.rt_cnt >= RST_TX) begin
                next_st.in_rst   = 1'b1;
                next_st.started  = 1'b0;
                next_st.root_set = 1'b0;
                next_st.bus      = CHBC_BUS_IDLE;
                next_st.half     = 1'b0;
                next_st.thr_run  = 1'b0;
            end
        end else begin
            next_st.rs_cnt = 3'h0;
            next_st.rt_cnt = 3'h0;
            next_st.in_rst = 1'b0;
        end

        // Port strobe latches host data on each rising edge
        if (sy.port && !st.port_d) begin
            next_st.port_reg = host_data_i;
            next_st.root_set = 1'b1;
        end

        // Attention taken on falling edge
        if (!st.in_rst && !sy.attn && st.attn_d) begin
            next_st.spulse = 1'b1;
            if (!st.started) begin
                next_st.started = 1'b1;
                next_st.skind   = CHBC_ATT_INIT;
                next_st.saddr   = st.root_set ? st.port_reg
                                              : CHBC_INIT_ROOT;
            end else begin
                next_st.skind   = CHBC_ATT_CMD;
                next_st.saddr   = '0;
            end
        end

        // External throttle trigger arms the tenure timer
        if (throttle_ext_mode_i && sy.trig && !st.trig_d) begin
            next_st.thr_run = 1'b1;
            next_st.thr_cnt = '0;
        end else if (st.thr_run && st.bus == CHBC_BUS_OWN) begin
            next_st.thr_cnt = st.thr_cnt + 1'b1;
        end

        // Bus ownership
        unique case (st.bus)
            CHBC_BUS_IDLE: begin
                if (xfer_req_i && !st.in_rst && !sy.grant)
                    next_st.bus = CHBC_BUS_REQ;
            end
            CHBC_BUS_REQ: begin
                if (sy.grant) begin
                    next_st.bus = CHBC_BUS_OWN;
                end
            end
            CHBC_BUS_OWN: begin
                if (!sy.grant) begin
                    // Early grant loss: count toward release
                    next_st.rel_cnt = st.rel_cnt + 1'b1;
                    if (st.rel_cnt + 1'b1 >= REL_LIM || !st.half)
                        next_st.bus = CHBC_BUS_DROP;
                end else if (st.thr_run && st.thr_cnt >= THR_LIM
                             && !st.half) begin
                    next_st.bus     = CHBC_BUS_DROP;
                    // A trigger in the same cycle re-arms the timer
                    next_st.thr_run = throttle_ext_mode_i && sy.trig
                                      && !st.trig_d;
                end else if (!st.bus_backoff_in && mem_ready_i && xfer_req_i) begin
                    word = byte_order_select_i ? xfer_data_i
                                               : swap(xfer_data_i);
                    next_st.mstb = 1'b1;
                    if (narrow_bus_select_n_i) begin
                        next_st.mdata = word;
                        next_st.done  = 1'b1;
                    end else if (!st.half) begin
                        next_st.half = 1'b1;
                        next_st.mdata = byte_order_select_i
                            ? {16'h0000, word[15:0]}
                            : {word[15:0], 16'h0000};
                    end else begin
                        next_st.half = 1'b0;
                        next_st.done = 1'b1;
                        next_st.mdata = byte_order_select_i
                            ? {16'h0000, word[31:16]}
                            : {word[31:16], 16'h0000};
                    end
                end
                if (sy.grant)
                    next_st.rel_cnt = '0;
            end
            CHBC_BUS_DROP: begin
                // Request low; wait for arbiter to drop grant
                next_st.rel_cnt = '0;
                if (!sy.grant)
                    next_st.bus = CHBC_BUS_IDLE;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st     <= '0;
            st.bus <= CHBC_BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bus_request_o  = (st.bus == CHBC_BUS_REQ)
                         || (st.bus == CHBC_BUS_OWN);
    assign bus_owned_o    = (st.bus == CHBC_BUS_OWN);
    assign bus_drive_o    = (st.bus == CHBC_BUS_OWN) && !st.bus_backoff_in;
    assign mem_data_o     = st.mdata;
    assign mem_strobe_o   = st.mstb;
    assign xfer_done_o    = st.done;
    assign port_latch_o   = st.port_reg;
    assign device_reset_o = st.in_rst;
    assign start_pulse_o  = st.spulse;
    assign start_kind_o   = st.skind;
    assign start_addr_o   = st.saddr;
    assign interrupt_o    = st.irq ^ ~irq_active_high_i;
endmodule
`default_nettype wire

/* verilog/chbc_pkg.sv */
package chbc_pkg;
    // ************************************************************
    // Widths and fixed values
    // ************************************************************
    localparam int          CHBC_DATA_W       = 32;  // Host data bus width
    localparam int          CHBC_HALF_W       = 16;  // Narrow bus lane width
    localparam logic [31:0] CHBC_INIT_ROOT    = 32'h00FFFFF6; // Default root
    localparam int          CHBC_RST_SYS_MIN  = 5;   // Reset system clocks
    localparam int          CHBC_RST_TX_MIN   = 4;   // Reset transmit clocks
    localparam int          CHBC_RELEASE_MAX  = 8;   // Default release bound
    localparam int          CHBC_THROTTLE_DEF = 64;  // Default tenure cycles
    localparam int          CHBC_CNT_W        = 16;  // Counter width

    // ************************************************************
    // Bus ownership states
    // ************************************************************
    typedef enum logic [1:0] {
        CHBC_BUS_IDLE,
        CHBC_BUS_REQ,
        CHBC_BUS_OWN,
        CHBC_BUS_DROP
    } chbc_bus_t;

    // Attention dispatch kinds
    typedef enum logic [1:0] {
        CHBC_ATT_NONE,
        CHBC_ATT_INIT,
        CHBC_ATT_CMD
    } chbc_att_t;
endpackage

/* verilog/chbc_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Synchronised pin levels passed from the sync stage to the main module
interface chbc_sync_if;
    logic grant;   // Bus grant level
    logic attn;    // Attention strobe level
    logic rst;     // Reset level
    logic serial_transmit_clock;     // Transmit clock level
    logic trig;    // Throttle trigger level
    logic port;    // Port strobe level
    modport src (output grant, attn, rst, serial_transmit_clock, trig, port);
    modport dst (input  grant, attn, rst, serial_transmit_clock, trig, port);
endinterface
`default_nettype wire

/* verilog/chbc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchronisers for six asynchronous pins; backoff has its own in chbc_top
module chbc_sync
    import chbc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic [5:0] pins_i,
    chbc_sync_if.src  sync
);
    // ************************************************************
    // Synchroniser state
    // ************************************************************
    typedef struct packed {
        logic [5:0] first;   // First stage, read only by second
        logic [5:0] second;  // Stable synchronised levels
    } chbc_sync_st_t;

    chbc_sync_st_t st;
    chbc_sync_st_t next_st;

    // Shift stages
    always_comb begin
        next_st.first  = pins_i;
        next_st.second = st.first;
    end

    // Register stages
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync.grant = st.second[0];
    assign sync.attn  = st.second[1];
    assign sync.rst   = st.second[2];
    assign sync.serial_transmit_clock   = st.second[3];
    assign sync.trig  = st.second[4];
    assign sync.port  = st.second[5];
endmodule
`default_nettype wire

/* tb/chbc_arb_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Local bus arbiter and memory partner
// ****************************************
module chbc_arb_model (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic req_i,    // Request from the block
    input  wire logic yank_i,   // Pull grant away while request stands
    input  wire logic slow_i,   // Late grant and stalling memory
    output logic      grant_o,  // Grant to the block
    output logic      ready_o   // Memory ready
);
    logic [2:0] wait_cnt;       // Grant latency counter
    logic [3:0] lfsr;           // Stall pattern
    // Grant follows request; dropped after request goes low or on yank
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            grant_o  <= 1'b0;
            wait_cnt <= 3'h0;
            lfsr     <= 4'h9;
        end else begin
            lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
            if (grant_o) begin
                if (!req_i || yank_i) begin
                    grant_o <= 1'b0;
                end
            end else if (req_i && !yank_i) begin
                if (wait_cnt == (slow_i ? 3'h5 : 3'h1)) begin
                    grant_o  <= 1'b1;
                    wait_cnt <= 3'h0;
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end
        end
    end
    // Stalls follow a changing pattern when slow
    assign ready_o = !slow_i | lfsr[0];
endmodule
`default_nettype wire

/* tb/chbc_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the host bus control
// ****************************************
module chbc_top_sva #(
    parameter int RELEASE_MAX = 8
)(
    input wire logic clock_i, rst_i, hw_reset_i, bus_mastership_grant_i,
    input wire logic host_attention_strobe_i, port_strobe_i,
    input wire logic [31:0] host_data_i, port_latch_o,
    input wire logic bus_backoff_in_n_i, irq_event_i, irq_active_high_i,
    input wire logic bus_request_o, bus_owned_o, bus_drive_o, mem_strobe_o,
    input wire logic xfer_done_o, device_reset_o, start_pulse_o, interrupt_o
);
    localparam int REL_B = RELEASE_MAX + 4; // Sync plus release bound
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_irq_polarity: assert property (!$past(rst_i) |-> interrupt_o ==
        ($past(irq_event_i) ^ !irq_active_high_i)) else $error("irq level");
    a_attn_start: assert property ($fell(host_attention_strobe_i)
        && !device_reset_o && !hw_reset_i |-> ##[3:4] start_pulse_o)
        else $error("attention start missing");
    a_release_bound: assert property ($fell(bus_mastership_grant_i)
        && bus_request_o |-> ##[1:REL_B] !bus_request_o)
        else $error("request held too long");
    a_grant_owned: assert property ($rose(bus_mastership_grant_i)
        && bus_request_o |-> ##[2:3] bus_owned_o) else $error("not owned");
    a_backoff_float: assert property (!bus_backoff_in_n_i [*3]
        |-> !bus_drive_o) else $error("bus driven in backoff");
    a_drive_owned: assert property (bus_drive_o |-> bus_owned_o
        && bus_request_o) else $error("drive without ownership");
    a_done_strobe: assert property (xfer_done_o |-> mem_strobe_o)
        else $error("done without access");
    a_port_latch: assert property ($rose(port_strobe_i)
        |-> ##4 port_latch_o == host_data_i) else $error("latch wrong");
    a_reset_entry: assert property ($rose(device_reset_o)
        |-> $past(hw_reset_i, 5) && $past(hw_reset_i, 3))
        else $error("reset too early");
    a_reset_leave: assert property (!hw_reset_i [*6] |-> !device_reset_o)
        else $error("reset stuck");
    a_reset_quiet: assert property (device_reset_o |-> !start_pulse_o)
        else $error("start during reset");
endmodule
bind chbc_top chbc_top_sva #(.RELEASE_MAX(RELEASE_MAX)) i_chbc_top_sva (
    .clock_i(clock_i), .rst_i(rst_i), .hw_reset_i(hw_reset_i),
    .bus_mastership_grant_i(bus_mastership_grant_i),
    .host_attention_strobe_i(host_attention_strobe_i),
    .port_strobe_i(port_strobe_i), .host_data_i(host_data_i),
    .port_latch_o(port_latch_o), .bus_backoff_in_n_i(bus_backoff_in_n_i),
    .irq_event_i(irq_event_i), .irq_active_high_i(irq_active_high_i),
    .bus_request_o(bus_request_o), .bus_owned_o(bus_owned_o),
    .bus_drive_o(bus_drive_o), .mem_strobe_o(mem_strobe_o),
    .xfer_done_o(xfer_done_o), .device_reset_o(device_reset_o),
    .start_pulse_o(start_pulse_o), .interrupt_o(interrupt_o));
`default_nettype wire

/* tb/chbc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module chbc_top_tb;
    import chbc_pkg::*;
    logic clock_i = 0, rst_i = 1, hw_rst = 0, ser_clk = 0, attn = 0;
    logic port = 0, nar_n = 1, order = 1, backoff_n = 1, xreq = 0, irq = 0;
    logic pol = 1, trig = 0, tmode = 0, yank = 0, slow = 0, grant, ready;
    logic [31:0] hdata = 0, xdata = 0, mdata, latch, saddr, rng = 32'h10;
    logic [31:0] root;
    logic req, owned, drive, mstb, done, dres, spul, first, intr;
    logic [1:0] skind;
    logic [34:0] exp_q[$], e;   // Start notes: compare-address flag, kind, addr
    logic [63:0] mem_q[$], m;   // Access notes: lane mask, lane data
    int failures = 0, checks_done = 0, cycles = 0;
    always #10 clock_i = ~clock_i;
    always #17 ser_clk = ~ser_clk; // Free running transmit clock
    chbc_top #(.RELEASE_MAX(8), .THROTTLE_MAX(16)) i_chbc_top (
        .clock_i(clock_i), .rst_i(rst_i), .hw_reset_i(hw_rst),
        .serial_transmit_clock_i(ser_clk), .bus_mastership_grant_i(grant),
        .throttle_trigger_in_i(trig), .throttle_ext_mode_i(tmode),
        .host_attention_strobe_i(attn), .port_strobe_i(port),
        .host_data_i(hdata), .narrow_bus_select_n_i(nar_n),
        .byte_order_select_i(order), .bus_backoff_in_n_i(backoff_n),
        .xfer_req_i(xreq), .xfer_data_i(xdata), .mem_ready_i(ready),
        .irq_event_i(irq), .irq_active_high_i(pol), .bus_request_o(req),
        .bus_owned_o(owned), .bus_drive_o(drive), .mem_data_o(mdata),
        .mem_strobe_o(mstb), .xfer_done_o(done), .port_latch_o(latch),
        .device_reset_o(dres), .start_pulse_o(spul), .start_kind_o(skind),
        .start_addr_o(saddr), .interrupt_o(intr));
    chbc_arb_model i_chbc_arb_model (.clock_i(clock_i), .rst_i(rst_i),
        .req_i(req), .yank_i(yank), .slow_i(slow), .grant_o(grant),
        .ready_o(ready));
    function logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask
    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Outputs are taken off the notes at mid cycle
    always @(negedge clock_i) begin
        if (!rst_i && spul) begin
            if (exp_q.size() == 0) check(34'h1, 34'h0);
            else begin
                e = exp_q.pop_front();
                check({skind, e[34] ? saddr : 32'h0}, e[33:0]);
            end
        end
        if (!rst_i && mstb) begin
            if (mem_q.size() == 0) check(34'h1, 34'h0);
            else begin
                m = mem_q.pop_front();
                check({2'h0, mdata & m[63:32]}, {2'h0, m[31:0]});
            end
        end
    end
    // Hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results;
        end
    end
    // Attention pulse with the expected dispatch noted first
    task attn_pulse;
        if (first) exp_q.push_back({1'b1, CHBC_ATT_INIT, root});
        else exp_q.push_back({1'b0, CHBC_ATT_CMD, 32'h0});
        first = 0;
        attn = 1;
        tick(2);
        attn = 0;
        tick(8);
    endtask
    task port_wr(input logic [31:0] d);
        hdata = d;
        port = 1;
        tick(2);
        port = 0;
        tick(5);
        check({2'h0, latch}, {2'h0, d});
    endtask
    // One word across the bus; lanes noted per access
    task xfer(input logic [31:0] w, input logic n, input logic le);
        logic [31:0] s;
        s = {w[7:0], w[15:8], w[23:16], w[31:24]};
        xdata = w;
        nar_n = n;
        order = le;
        if (n) mem_q.push_back({32'hFFFFFFFF, le ? w : s});
        else if (le) begin
            mem_q.push_back({32'h0000FFFF, 16'h0, w[15:0]});
            mem_q.push_back({32'h0000FFFF, 16'h0, w[31:16]});
        end else begin
            mem_q.push_back({32'hFFFF0000, s[15:0], 16'h0});
            mem_q.push_back({32'hFFFF0000, s[31:16], 16'h0});
        end
        xreq = 1;
        for (int k = 0; k < 400 && done !== 1'b1; k++) tick(1);
        check({33'h0, done}, 34'h1);
        xreq = 0;
        tick(2);
    endtask
    initial begin
        tick(4);
        rst_i = 0;
        root = CHBC_INIT_ROOT;
        first = 1;
        tick(20); // No start may appear before attention
        attn_pulse;
        attn_pulse;
        $display("attention test done");
        hw_rst = 1;
        tick(14);
        check({33'h0, dres}, 34'h1);
        hw_rst = 0;
        tick(8);
        check({33'h0, dres}, 34'h0);
        first = 1;
        rng = xs(rng);
        port_wr(rng);
        rng = xs(rng);
        port_wr(rng);
        root = rng;
        attn_pulse;
        attn_pulse;
        $display("reset and root test done");
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            slow = i[2];
            xfer(rng, i[0], i[1]);
        end
        slow = 0;
        $display("transfer test done");
        rng = xs(rng);
        fork
            xfer(rng, 1'b1, 1'b1);
            begin
                tick(5);
                yank = 1;
                tick(20);
                yank = 0;
            end
        join
        check({33'h0, req}, 34'h0);
        rng = xs(rng);
        fork
            xfer(rng, 1'b1, 1'b1);
            begin
                tick(3);
                backoff_n = 0;
                tick(5);
                check({32'h0, owned, drive}, 34'h2);
                backoff_n = 1;
            end
        join
        tmode = 1;
        rng = xs(rng);
        fork
            xfer(rng, 1'b0, 1'b1);
            begin
                tick(5);
                trig = 1;
                tick(3);
                trig = 0;
            end
        join
        tick(24);
        check({33'h0, req}, 34'h0);
        $display("release test done");
        for (int i = 0; i < 40; i++) begin
            rng = xs(rng);
            irq = rng[3];
            pol = (i < 20);
            tick(1);
            check({33'h0, intr}, {33'h0, irq ^ !pol});
        end
        $display("interrupt test done");
        tick(10);
        check(34'(mem_q.size()), 34'h0);
        check(34'(exp_q.size()), 34'h0);
        results;
    end
endmodule
`default_nettype wire
